// [common/dpc_params.svh]
// constants of the debug port control and status block
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// ************************************************
// register offsets
// ************************************************
`define DPC_OFS_REVISION 4'h0
`define DPC_OFS_ERROR 4'h1
`define DPC_OFS_PHY_CTRL 4'h2
`define DPC_OFS_PORT_CTRL 4'h3
`define DPC_OFS_KEY_STATUS 4'h7
`define DPC_OFS_RESET_REQ 4'h8

// ************************************************
// field positions
// ************************************************
`define DPC_BIT_INTER_BYTE_DELAY_EN 7
`define DPC_BIT_PARITY_IGN 5
`define DPC_BIT_TIMEOUT_OFF 4
`define DPC_BIT_RESP_OFF 3
`define DPC_BIT_NACK_SUPP 4
`define DPC_BIT_CONT_OFF 3
`define DPC_BIT_PORT_DIS 2
`define DPC_BIT_UROW_KEY 5
`define DPC_BIT_NVM_KEY 4
`define DPC_BIT_ERASE_KEY 3

// ************************************************
// reset values and codes
// ************************************************
`define DPC_RST_BYTE 8'h00
`define DPC_RESET_SIG 8'h59
`define DPC_RUN_SIG 8'h00
`define DPC_ERR_NONE 3'h0
`define DPC_ERR_PARITY 3'h1
`define DPC_ERR_FRAME 3'h2
`define DPC_ERR_TIMEOUT 3'h3
`define DPC_ERR_CLOCK 3'h4
`define DPC_ERR_BUS 3'h6
`define DPC_ERR_CONTENTION 3'h7
`define DPC_GT_RESERVED 3'h7
`define DPC_GT_DEFAULT 3'h0

// ************************************************
// timing counts
// ************************************************
`define DPC_CNT_W 17
`define DPC_GUARD_MAX 17'h00080
`define DPC_TIMEOUT_CYCLES 65536
`define DPC_IDLE_BITS 2
`define DPC_BIT_CYCLES 4

`endif

// [common/dpc_pkg.sv]
// types of the debug port control and status block
`include "dpc_params.svh"

package dpc_pkg;

    // register access from the link layer
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dpc_reg_req_s;

    // configuration seen by the link layer
    typedef struct packed {
        logic inter_byte_delay_en;
        logic parity_ignore;
        logic timeout_detect_off;
        logic response_sig_off;
        logic [2:0] guard_time_sel;
        logic nack_suppress;
        logic contention_detect_off;
    } dpc_cfg_s;

    // state of the delay counter
    typedef struct packed {
        logic [`DPC_CNT_W-1:0] cnt;
        logic busy;
        logic done;
    } dpc_dly_s;

    // state of the register block
    typedef struct packed {
        logic enabled;
        dpc_cfg_s cfg;
        logic [2:0] error_signature;
        logic user_row_key_flag;
        logic nvm_prog_key_flag;
        logic erase_key_flag;
        logic [7:0] reset_request_value;
        logic [7:0] rdata;
        logic rvalid;
        logic nack_pulse;
        logic session_end;
        logic sys_reset_q;
    } dpc_state_s;

endpackage

// [core/dpc_delay.sv]
// down counter that times one delay after a start pulse
`timescale 1ns/10ps
`include "dpc_params.svh"

module dpc_delay (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // control
    input wire logic start_i,
    input wire logic cancel_i,
    input wire logic [`DPC_CNT_W-1:0] load_i,
    // status
    output logic busy_o,
    output logic done_o
);

    dpc_pkg::dpc_dly_s st;
    dpc_pkg::dpc_dly_s next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (cancel_i) begin
            next_st.busy = 1'b0;
            next_st.cnt = '0;
        end else if (start_i) begin
            // a zero load still takes one cycle
            next_st.busy = 1'b1;
            next_st.cnt = (load_i == '0) ? `DPC_CNT_W'(1) : load_i;
        end else if (st.busy) begin
            if (st.cnt == `DPC_CNT_W'(1)) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
            next_st.cnt = st.cnt - `DPC_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy_o = st.busy;
    assign done_o = st.done;

endmodule

// [core/dpc_regs.sv]
// control and status registers of the single-pin debug port
// Notes on behaviour
// - registers reachable only through the debug link
// - read-only revision in status bits 7:4
// - error field loads on error, clears on read
// - error codes fixed per error kind
// - inter-byte delay adds two idle bits
// - parity ignore bit skips parity checks
// - access response times out after 65536 cycles
// - response signature off bit suppresses signatures
// - guard time 128 down to 2 cycles
// - nack suppress bit blocks nack on reset
// - contention detection runs while off bit clear
// - port disable drops clock, resets config, keys
// - user-row key flag set on decode, written last
// - nvm key flag clears when programming starts
// - erase key flag clears on reset request
// - system held in reset while value 0x59
// - system reset leaves port state untouched
// - key flags reset to zero, user-row writable
// - clock request high while port enabled
`timescale 1ns/10ps
`include "dpc_params.svh"

module dpc_regs #(
    parameter logic [3:0] REVISION = 4'h1, // arbitrary value
    parameter int TIMEOUT_CYCLES = `DPC_TIMEOUT_CYCLES,
    parameter int BIT_CYCLES = `DPC_BIT_CYCLES
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // register access from the link layer
    input wire dpc_pkg::dpc_reg_req_s REG_REQ_I,
    output logic [7:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    // error reports from the link layer
    input wire logic PARITY_ERR_I,
    input wire logic CONTENTION_I,
    input wire logic ERR_VALID_I,
    input wire logic [2:0] ERR_CODE_I,
    // access layer handshake
    input wire logic ACC_REQ_I,
    input wire logic ACC_ACK_I,
    output logic TIMEOUT_O,
    // transmit timing
    input wire logic TURNAROUND_I,
    output logic GUARD_BUSY_O,
    input wire logic MULTI_BYTE_SENT_I,
    output logic TX_HOLD_O,
    // load and store in progress
    input wire logic LDST_BUSY_I,
    output logic NACK_SEND_O,
    // key decoding and system status
    input wire logic USER_ROW_KEY_I,
    input wire logic NVM_PROG_KEY_I,
    input wire logic ERASE_KEY_I,
    input wire logic NVM_PROG_STATUS_I,
    input wire logic PORT_ENABLE_I,
    // outputs to the link and the system
    output dpc_pkg::dpc_cfg_s CFG_O,
    output logic RESP_SIG_EN_O,
    output logic PARITY_CHECK_EN_O,
    output logic CONTENTION_DET_EN_O,
    output logic PORT_ENABLED_O,
    output logic PORT_RESET_O,
    output logic SYSTEM_CLOCK_REQUEST_O,
    output logic SYS_RESET_O,
    output logic SESSION_END_O
);

    // ************************************************
    // parameter checks
    // ************************************************
    localparam int GAP_CYCLES = `DPC_IDLE_BITS * BIT_CYCLES;

    generate
        if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << `DPC_CNT_W))
        begin : g_bad_timeout
            $error("timeout count does not fit the counter");
        end
        if (BIT_CYCLES < 1 || GAP_CYCLES >= (1 << `DPC_CNT_W)) begin : g_bad_bit
            $error("bit time does not fit the counter");
        end
    endgenerate

    dpc_pkg::dpc_state_s st;
    dpc_pkg::dpc_state_s next_st;

    // ************************************************
    // error sources
    // ************************************************
    logic timeout_done;
    logic err_hit;
    logic [2:0] err_code;
    logic port_dis_wr;
    logic [`DPC_CNT_W-1:0] guard_load;
    logic [2:0] guard_code;
    logic wr_hit;
    logic rd_hit;

    assign wr_hit = REG_REQ_I.wr && st.enabled;
    assign rd_hit = REG_REQ_I.rd && st.enabled;
    assign port_dis_wr = wr_hit && REG_REQ_I.addr == `DPC_OFS_PORT_CTRL
        && REG_REQ_I.wdata[`DPC_BIT_PORT_DIS];

    always_comb begin
        err_hit = 1'b1;
        err_code = `DPC_ERR_NONE;
        if (CONTENTION_I && !st.cfg.contention_detect_off) begin
            err_code = `DPC_ERR_CONTENTION;
        // parity error gated by ignore bit
        end else if (PARITY_ERR_I && !st.cfg.parity_ignore) begin
            err_code = `DPC_ERR_PARITY;
        end else if (timeout_done) begin
            err_code = `DPC_ERR_TIMEOUT;
        end else if (ERR_VALID_I && ERR_CODE_I != 3'h5
                && ERR_CODE_I != `DPC_ERR_NONE) begin
            err_code = ERR_CODE_I;
        end else begin
            err_hit = 1'b0;
        end
    end

    // ************************************************
    // guard time selection
    // ************************************************
    always_comb begin
        guard_code = st.cfg.guard_time_sel;
        // reserved code falls back to default
        if (guard_code == `DPC_GT_RESERVED) begin
            guard_code = `DPC_GT_DEFAULT;
        end
        guard_load = `DPC_GUARD_MAX >> guard_code;
    end

    // ************************************************
    // register state
    // ************************************************
    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.nack_pulse = 1'b0;
        next_st.session_end = 1'b0;
        next_st.sys_reset_q = SYS_RESET_O;
        if (PORT_ENABLE_I) begin
            next_st.enabled = 1'b1;
        end

        if (rd_hit) begin
            next_st.rvalid = 1'b1;
            case (REG_REQ_I.addr)
                `DPC_OFS_REVISION: next_st.rdata = {REVISION, 4'h0};
                `DPC_OFS_ERROR: next_st.rdata = {5'h00, st.error_signature};
                `DPC_OFS_PHY_CTRL: begin
                    next_st.rdata = {st.cfg.inter_byte_delay_en, 1'b0,
                        st.cfg.parity_ignore, st.cfg.timeout_detect_off,
                        st.cfg.response_sig_off, st.cfg.guard_time_sel};
                end
                `DPC_OFS_PORT_CTRL: begin
                    next_st.rdata = {3'h0, st.cfg.nack_suppress,
                        st.cfg.contention_detect_off, 3'h0};
                end
                `DPC_OFS_KEY_STATUS: begin
                    next_st.rdata = {2'h0, st.user_row_key_flag,
                        st.nvm_prog_key_flag, st.erase_key_flag, 3'h0};
                end
                `DPC_OFS_RESET_REQ: next_st.rdata = st.reset_request_value;
                default: next_st.rdata = `DPC_RST_BYTE;
            endcase
            if (REG_REQ_I.addr == `DPC_OFS_ERROR) begin
                next_st.error_signature = `DPC_ERR_NONE;
            end
        end

        if (wr_hit) begin
            case (REG_REQ_I.addr)
                `DPC_OFS_PHY_CTRL: begin
                    next_st.cfg.inter_byte_delay_en =
                        REG_REQ_I.wdata[`DPC_BIT_INTER_BYTE_DELAY_EN];
                    next_st.cfg.parity_ignore =
                        REG_REQ_I.wdata[`DPC_BIT_PARITY_IGN];
                    next_st.cfg.timeout_detect_off =
                        REG_REQ_I.wdata[`DPC_BIT_TIMEOUT_OFF];
                    next_st.cfg.response_sig_off =
                        REG_REQ_I.wdata[`DPC_BIT_RESP_OFF];
                    next_st.cfg.guard_time_sel = REG_REQ_I.wdata[2:0];
                end
                `DPC_OFS_PORT_CTRL: begin
                    next_st.cfg.nack_suppress =
                        REG_REQ_I.wdata[`DPC_BIT_NACK_SUPP];
                    next_st.cfg.contention_detect_off =
                        REG_REQ_I.wdata[`DPC_BIT_CONT_OFF];
                end
                `DPC_OFS_KEY_STATUS: begin
                    next_st.user_row_key_flag =
                        REG_REQ_I.wdata[`DPC_BIT_UROW_KEY];
                    next_st.session_end = 1'b1;
                end
                `DPC_OFS_RESET_REQ: begin
                    next_st.reset_request_value = REG_REQ_I.wdata;
                    if (REG_REQ_I.wdata == `DPC_RESET_SIG) begin
                        next_st.erase_key_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        if (NVM_PROG_STATUS_I) begin
            next_st.nvm_prog_key_flag = 1'b0;
        end
        // key decode sets win over clears, but a port disable write still clears the flags
        if (st.enabled && USER_ROW_KEY_I) begin
            next_st.user_row_key_flag = 1'b1;
        end
        if (st.enabled && NVM_PROG_KEY_I) begin
            next_st.nvm_prog_key_flag = 1'b1;
        end
        if (st.enabled && ERASE_KEY_I) begin
            next_st.erase_key_flag = 1'b1;
        end
        // new error wins over read clear
        if (st.enabled && err_hit) begin
            next_st.error_signature = err_code;
        end
        // nack on reset during load or store
        if (SYS_RESET_O && !st.sys_reset_q && LDST_BUSY_I
                && !st.cfg.nack_suppress) begin
            next_st.nack_pulse = 1'b1;
        end

        if (port_dis_wr) begin
            next_st = '0;
            next_st.sys_reset_q = SYS_RESET_O;
        end
    end

    // the port reset input clears this but leaves the port enabled; a port disable write clears all of it but sys_reset_q, which takes SYS_RESET_O
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st <= '0;
            st.enabled <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************
    // timers
    // ************************************************
    // wait for access layer answer
    dpc_delay u_timeout (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .start_i(ACC_REQ_I && st.enabled && !st.cfg.timeout_detect_off),
        .cancel_i(ACC_ACK_I || !st.enabled || st.cfg.timeout_detect_off),
        .load_i(`DPC_CNT_W'(TIMEOUT_CYCLES)),
        .busy_o(),
        .done_o(timeout_done)
    );

    dpc_delay u_guard (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .start_i(TURNAROUND_I && st.enabled),
        .cancel_i(!st.enabled),
        .load_i(guard_load),
        .busy_o(GUARD_BUSY_O),
        .done_o()
    );

    // two idle bits between load bytes
    dpc_delay u_gap (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .start_i(MULTI_BYTE_SENT_I && st.cfg.inter_byte_delay_en),
        .cancel_i(!st.enabled),
        .load_i(`DPC_CNT_W'(GAP_CYCLES)),
        .busy_o(TX_HOLD_O),
        .done_o()
    );

    // ************************************************
    // outputs
    // ************************************************
    // read data only on the link register port
    assign REG_RDATA_O = st.rdata;
    assign REG_RVALID_O = st.rvalid;
    assign TIMEOUT_O = timeout_done;
    assign NACK_SEND_O = st.nack_pulse;
    assign SESSION_END_O = st.session_end;
    assign CFG_O = st.cfg;
    assign RESP_SIG_EN_O = !st.cfg.response_sig_off;
    assign PARITY_CHECK_EN_O = !st.cfg.parity_ignore;
    assign CONTENTION_DET_EN_O = !st.cfg.contention_detect_off;
    assign PORT_ENABLED_O = st.enabled;
    assign PORT_RESET_O = !st.enabled;
    assign SYSTEM_CLOCK_REQUEST_O = st.enabled;
    assign SYS_RESET_O = st.reset_request_value == `DPC_RESET_SIG;

endmodule

// [bench/dpc_dbg_model.sv]
// debugger model driving register accesses over the link layer
`timescale 1ns/10ps

module dpc_dbg_model (
    // clock
    input wire logic clk_i,
    // register access toward the port
    output dpc_pkg::dpc_reg_req_s req_o
);
    // idle cycles before each access, slows the debugger down
    int idle = 0;

    initial req_o = '0;

    // ************************************************
    // one access per call
    // ************************************************
    // debugger side duties
    // fixed latency here, so signatures may be switched off safely;
    // the bench writes the user-row flag last and releases with 0x00
    task automatic access(input logic w, input logic [3:0] a,
                          input logic [7:0] d);
        repeat (idle) @(posedge clk_i);
        @(posedge clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        // released bus shows inverted values, not the last ones
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// [bench/dpc_regs_props.sv]
// concurrent checks on the ports of the register block
`timescale 1ns/10ps

module dpc_regs_props #(
    parameter logic [3:0] REVISION = 4'h1
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // watched ports
    input wire dpc_pkg::dpc_reg_req_s REG_REQ_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic REG_RVALID_O,
    input wire logic TURNAROUND_I,
    input wire logic GUARD_BUSY_O,
    input wire logic TIMEOUT_O,
    input wire logic NACK_SEND_O,
    input wire dpc_pkg::dpc_cfg_s CFG_O,
    input wire logic PARITY_CHECK_EN_O,
    input wire logic CONTENTION_DET_EN_O,
    input wire logic PORT_ENABLED_O,
    input wire logic SYSTEM_CLOCK_REQUEST_O,
    input wire logic SYS_RESET_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    // ************************************************
    // sequences and checks
    // ************************************************
    sequence guard_two_s;
        GUARD_BUSY_O [*2] ##1 !GUARD_BUSY_O;
    endsequence

    rd_answer_a: assert property (
        REG_REQ_I.rd && PORT_ENABLED_O |=> REG_RVALID_O)
        else $error("read not answered");
    rev_read_a: assert property (
        REG_REQ_I.rd && REG_REQ_I.addr == 4'h0 && PORT_ENABLED_O
        |=> REG_RDATA_O == {REVISION, 4'h0})
        else $error("revision read wrong");
    sys_hold_a: assert property (
        REG_REQ_I.wr && REG_REQ_I.addr == 4'h8 && PORT_ENABLED_O
        && REG_REQ_I.wdata == 8'h59 |=> SYS_RESET_O)
        else $error("system reset not held");
    port_off_a: assert property (
        REG_REQ_I.wr && REG_REQ_I.addr == 4'h3 && PORT_ENABLED_O
        && REG_REQ_I.wdata[2] |=> !PORT_ENABLED_O && CFG_O == '0)
        else $error("port disable incomplete");
    clk_req_a: assert property (
        SYSTEM_CLOCK_REQUEST_O == PORT_ENABLED_O)
        else $error("clock request wrong");
    parity_en_a: assert property (
        PARITY_CHECK_EN_O != CFG_O.parity_ignore)
        else $error("parity enable wrong");
    cont_en_a: assert property (
        CONTENTION_DET_EN_O != CFG_O.contention_detect_off)
        else $error("contention enable wrong");
    guard_two_a: assert property (
        TURNAROUND_I && PORT_ENABLED_O && !GUARD_BUSY_O
        && CFG_O.guard_time_sel == 3'h6 |=> guard_two_s)
        else $error("short guard wrong");
    nack_gate_a: assert property (
        NACK_SEND_O |-> SYS_RESET_O && !CFG_O.nack_suppress)
        else $error("nack not allowed");
    timeout_gate_a: assert property (
        TIMEOUT_O |-> !CFG_O.timeout_detect_off)
        else $error("timeout while disabled");
endmodule

bind dpc_regs dpc_regs_props #(.REVISION(REVISION)) u_props (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .REG_REQ_I(REG_REQ_I),
    .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
    .TURNAROUND_I(TURNAROUND_I), .GUARD_BUSY_O(GUARD_BUSY_O),
    .TIMEOUT_O(TIMEOUT_O), .NACK_SEND_O(NACK_SEND_O), .CFG_O(CFG_O),
    .PARITY_CHECK_EN_O(PARITY_CHECK_EN_O),
    .CONTENTION_DET_EN_O(CONTENTION_DET_EN_O),
    .PORT_ENABLED_O(PORT_ENABLED_O),
    .SYSTEM_CLOCK_REQUEST_O(SYSTEM_CLOCK_REQUEST_O),
    .SYS_RESET_O(SYS_RESET_O));

// [bench/tb_dpc_regs.sv]
// self-checking bench of the debug port register block
`timescale 1ns/10ps

module tb_dpc_regs;
    localparam logic [3:0] REV = 4'h1; // arbitrary value
    localparam int TMO = 20;
    localparam int BITC = 4;
    logic CLK_I;
    logic RSTN_I;
    logic [10:0] pl;
    logic [2:0] code;
    logic ldst;
    logic nvm_st;
    dpc_pkg::dpc_reg_req_s req;
    dpc_pkg::dpc_cfg_s cfg;
    logic [7:0] rdata;
    logic rvalid, tmo, guard, hold, nack, resp_en, par_en, cont_en;
    logic ena, system_clock_request, sysrst, sess, prst;
    int err_total;
    int checks;
    int n;
    logic [7:0] d;
    logic [3:0] ra [0:6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h5};
    logic [7:0] re [0:6] = '{{REV, 4'h0}, 0, 0, 0, 0, 0, 0};
    int ek [0:5] = '{0, 1, 2, 2, 2, 2};
    logic [2:0] ec [0:5] = '{0, 0, 2, 4, 6, 5};
    logic [7:0] ee [0:5] = '{1, 7, 2, 4, 6, 0};

    dpc_dbg_model u_dbg_model (.clk_i(CLK_I), .req_o(req));

    dpc_regs #(.REVISION(REV), .TIMEOUT_CYCLES(TMO), .BIT_CYCLES(BITC))
    u_dpc_regs (
        .CLK_I(CLK_I), .RSTN_I(RSTN_I), .REG_REQ_I(req),
        .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .PARITY_ERR_I(pl[0]), .CONTENTION_I(pl[1]), .ERR_VALID_I(pl[2]),
        .ERR_CODE_I(code), .ACC_REQ_I(pl[3]), .ACC_ACK_I(pl[10]),
        .TIMEOUT_O(tmo), .TURNAROUND_I(pl[4]), .GUARD_BUSY_O(guard),
        .MULTI_BYTE_SENT_I(pl[5]), .TX_HOLD_O(hold),
        .LDST_BUSY_I(ldst), .NACK_SEND_O(nack),
        .USER_ROW_KEY_I(pl[6]), .NVM_PROG_KEY_I(pl[7]),
        .ERASE_KEY_I(pl[8]), .NVM_PROG_STATUS_I(nvm_st),
        .PORT_ENABLE_I(pl[9]), .CFG_O(cfg), .RESP_SIG_EN_O(resp_en),
        .PARITY_CHECK_EN_O(par_en), .CONTENTION_DET_EN_O(cont_en),
        .PORT_ENABLED_O(ena), .PORT_RESET_O(prst),
        .SYSTEM_CLOCK_REQUEST_O(system_clock_request), .SYS_RESET_O(sysrst),
        .SESSION_END_O(sess));

    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end

    // ************************************************
    // helpers
    // ************************************************
    function automatic int exp_guard(input int g);
        return (g == 7) ? 128 : (128 >> g);
    endfunction

    function automatic logic pick(input int s);
        case (s)
            0: return guard;
            1: return hold;
            2: return tmo;
            3: return nack;
            default: return sess;
        endcase
    endfunction

    task cmp8(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got,
                     exp);
        end
    endtask

    task rd(input logic [3:0] a, input logic [7:0] e);
        u_dbg_model.access(1'b0, a, 8'h00);
        #1;
        cmp8({7'h0, rvalid}, 8'h01, "read valid");
        cmp8(rdata, e, "read data");
    endtask

    task wr(input logic [3:0] a, input logic [7:0] v);
        u_dbg_model.access(1'b1, a, v);
    endtask

    task pulse(input int s);
        @(posedge CLK_I);
        pl <= 11'h1 << s;
        @(posedge CLK_I);
        pl <= '0;
    endtask

    // counts high cycles of one output over a fixed window
    task count(input int s, input int e, input string m);
        n = 0;
        repeat (200) begin
            #1;
            if (pick(s) === 1'b1) n++;
            @(posedge CLK_I);
        end
        cmp8(n[7:0], e[7:0], m);
    endtask

    task end_sim;
        $display("comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #400000;
        err_total++;
        end_sim;
    end

    // ************************************************
    // tests
    // ************************************************
    initial begin
        RSTN_I = 1'b0;
        pl = '0;
        code = 3'h0;
        ldst = 1'b0;
        nvm_st = 1'b0;
        err_total = 0;
        checks = 0;
        void'($urandom(32'h6f1817d7));
        repeat (4) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        for (int i = 0; i < 7; i++) rd(ra[i], re[i]);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            @(posedge CLK_I);
            code <= ec[i];
            pulse(ek[i]);
            rd(4'h1, ee[i]);
            rd(4'h1, 8'h00);
        end
        pulse(3);
        count(2, 1, "timeout");
        rd(4'h1, 8'h03);
        pulse(3);
        pulse(10);
        count(2, 0, "acked timeout");
        wr(4'h2, 8'h10);
        pulse(3);
        count(2, 0, "timeout off");
        $display("test errors done");
        u_dbg_model.idle = 3;
        repeat (4) begin
            d = 8'($urandom) & 8'hbf;
            wr(4'h2, d);
            rd(4'h2, d);
            cmp8({5'h0, cfg.guard_time_sel}, {5'h0, d[2:0]}, "cfg");
            cmp8({7'h0, par_en}, {7'h0, !d[5]}, "parity");
            cmp8({7'h0, resp_en}, {7'h0, !d[3]}, "signature");
            d = 8'($urandom) & 8'h18;
            wr(4'h3, d);
            rd(4'h3, d);
            cmp8({7'h0, cont_en}, {7'h0, !d[3]}, "contention");
        end
        u_dbg_model.idle = 0;
        for (int g = 0; g < 8; g++) begin
            wr(4'h2, {5'h0, g[2:0]});
            pulse(4);
            count(0, exp_guard(g), "guard");
        end
        wr(4'h2, 8'h80);
        pulse(5);
        count(1, 2 * BITC, "byte gap");
        wr(4'h2, 8'h00);
        pulse(5);
        count(1, 0, "no gap");
        $display("test config done");
        wr(4'h2, 8'h25);
        wr(4'h3, 8'h00);
        ldst <= 1'b1;
        pulse(6);
        pulse(7);
        pulse(8);
        rd(4'h7, 8'h38);
        wr(4'h8, 8'h59);
        count(3, 1, "nack");
        cmp8({7'h0, sysrst}, 8'h01, "system reset");
        rd(4'h7, 8'h30);
        rd(4'h2, 8'h25);
        pulse(0);
        rd(4'h1, 8'h00);
        @(posedge CLK_I);
        nvm_st <= 1'b1;
        rd(4'h7, 8'h20);
        wr(4'h7, 8'h00);
        count(4, 1, "session end");
        rd(4'h7, 8'h00);
        wr(4'h8, 8'h00);
        #1;
        cmp8({7'h0, sysrst}, 8'h00, "reset release");
        wr(4'h3, 8'h10);
        wr(4'h8, 8'h59);
        count(3, 0, "nack off");
        wr(4'h8, 8'h00);
        ldst <= 1'b0;
        nvm_st <= 1'b0;
        $display("test keys done");
        pulse(8);
        wr(4'h3, 8'h04);
        #1;
        cmp8({5'h0, prst, ena, system_clock_request}, 8'h04, "disabled");
        u_dbg_model.access(1'b0, 4'h2, 8'h00);
        #1;
        cmp8({7'h0, rvalid}, 8'h00, "disabled read");
        pulse(9);
        #1;
        cmp8({5'h0, prst, ena, system_clock_request}, 8'h03, "enabled");
        rd(4'h2, 8'h00);
        rd(4'h7, 8'h00);
        $display("test disable done");
        end_sim;
    end
endmodule
